// ==== common/srx_baud_if.sv ====
interface srx_baud_if;
	logic [1:0] prescale;
	logic [2:0] rate;
	logic [7:0] fine;
	logic tick;

	modport cfg (output prescale, output rate, output fine, input tick);
	modport gen (input prescale, input rate, input fine, output tick);
endinterface

// ==== common/srx_map.svh ====
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SRX_OFS_STATUS 3'h0
`define SRX_OFS_DATA 3'h1
`define SRX_OFS_CTRL1 3'h2
`define SRX_OFS_CTRL2 3'h3
`define SRX_OFS_BAUD 3'h4
`define SRX_OFS_RXFINE 3'h5
`define SRX_OFS_TXFINE 3'h6

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SRX_ST_RXFULL 5
`define SRX_ST_IDLE 4
`define SRX_ST_OVR 3
`define SRX_ST_NOISE 2
`define SRX_ST_FRAME 1
`define SRX_C1_NINTH 7
`define SRX_C1_WORD9 4
`define SRX_C1_WAKE 3
`define SRX_C2_RXIE 5
`define SRX_C2_IDLEIE 4
`define SRX_C2_RXEN 2
`define SRX_C2_MUTE 1
`define SRX_BD_PRE_HI 7
`define SRX_BD_PRE_LO 6
`define SRX_BD_TX_HI 5
`define SRX_BD_TX_LO 3
`define SRX_BD_RX_HI 2
`define SRX_BD_RX_LO 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SRX_RST_REG 8'h00

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define SRX_PR_0 19'h00001
`define SRX_PR_1 19'h00003
`define SRX_PR_2 19'h00004
`define SRX_PR_3 19'h0000d
`define SRX_DIV_W 19
`define SRX_CNT_EDGE 4'h0
`define SRX_CNT_S3 4'h2
`define SRX_CNT_S5 4'h4
`define SRX_CNT_S7 4'h6
`define SRX_CNT_S8 4'h7
`define SRX_CNT_S10 4'h9
`define SRX_CNT_LAST 4'hf
`define SRX_BITS8 4'h8
`define SRX_BITS9 4'h9
`define SRX_IDLE8 8'h9f
`define SRX_IDLE9 8'haf

`endif

// ==== common/srx_pkg.sv ====
package srx_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b10,
		ST_STOP = 2'b11
	} srx_state_type;

	typedef logic [2:0] srx_addr_type;
	typedef logic [7:0] srx_byte_type;
endpackage

// ==== src/srx_baud.sv ====
`include "srx_map.svh"

module srx_baud #(
	parameter int DIV_W = `SRX_DIV_W
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Divider settings and sample tick
	srx_baud_if.gen bif
);
	import srx_pkg::*;

	function automatic logic [DIV_W-1:0] common_div(input logic [1:0] sel);
		case (sel)
			2'h0: common_div = DIV_W'(`SRX_PR_0);
			2'h1: common_div = DIV_W'(`SRX_PR_1);
			2'h2: common_div = DIV_W'(`SRX_PR_2);
			default: common_div = DIV_W'(`SRX_PR_3);
		endcase
	endfunction

	logic [DIV_W-1:0] limit;
	logic [DIV_W-1:0] cnt_ff;
	logic tick_ff;

	// Cycles per sample tick: common x power of two x fine divisor
	always_comb
	begin
		limit = DIV_W'(common_div(bif.prescale) << bif.rate);
		if (bif.fine != 8'h00)
		begin
			limit = DIV_W'(limit * DIV_W'(bif.fine));
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i || cnt_ff >= limit - DIV_W'(1))
		begin
			cnt_ff <= '0;
		end
		else
		begin
			cnt_ff <= cnt_ff + DIV_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			tick_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= (cnt_ff >= limit - DIV_W'(1));
		end
	end

	assign bif.tick = tick_ff;
endmodule

// ==== src/srx_top.sv ====
// Operation
// - Receiver enable starts start-bit search
// - Good word loads holding buffer, sets full
// - Full requests interrupt when enabled, unmasked
// - Full clears by status then data read
// - Break character reports as framing error
// - Idle frame sets flag, optional interrupt
// - Word while full sets overrun, keeps buffer
// - Overrun clears by status then data read
// - Majority of samples 8-10, noise if differ
// - Noise flag rises with full flag
// - Noise clears by status then data read
// - False start discarded, noise kept pending
// - Missing stop bit sets framing error
// - Framing error clears by status, data read
// - Baud is clock over 16, common, power
// - Nonzero fine divisor further divides baud
// - Mute blocks receive flags and interrupts
// - Idle frame wakes mute, no idle flag
// - Address mark wakes mute, word received
// - Ninth received bit goes to control one
// - Data shifts in least significant first
// - Sixteen samples per bit, resync each start
//
// Implementation choices: the strobed register port and the register addresses.
`include "srx_map.svh"

module srx_top (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Register port
	input wire srx_pkg::srx_addr_type addr_i,
	input wire srx_pkg::srx_byte_type wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output srx_pkg::srx_byte_type rdata_o,
	// Serial line and processor
	input wire logic rdi_i,
	input wire logic cpu_mask_i,
	output logic irq_o,
	output logic tx_tick_o
);
	import srx_pkg::*;

	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	function automatic logic differ3(input logic [2:0] s);
		differ3 = (s != 3'h0) && (s != 3'h7);
	endfunction

	srx_baud_if rx_bif ();
	srx_baud_if tx_bif ();

	srx_byte_type ctrl1_ff, ctrl2_ff, baud_ff, rxfine_ff, txfine_ff, hold_ff;
	logic rx_meta_ff, rx_sync_ff;
	srx_state_type state_ff;
	logic [3:0] samp_cnt_ff, bit_cnt_ff;
	logic [8:0] shift_ff;
	logic [2:0] trio_ff, hist_ff;
	logic early_ff, edge_ok_ff, frame_noise_ff, pend_noise_ff;
	logic [7:0] idle_cnt_ff;
	logic idle_armed_ff;
	logic rxfull_ff, idle_ff, ovr_ff, noise_ff, frame_ff, arm_ff, mute_ff, irq_ff;
	srx_byte_type rdata_ff;
	logic tk, re, word9, wake, bit_end, word_done, msb, accept, wake_addr;
	logic load, ovr_evt, idle_evt, clr, noise_now;
	logic [3:0] bits_len;
	logic [7:0] idle_len;
	srx_byte_type status, data_val;

	// ------------------------------------------------------------
	// Baud generators
	// ------------------------------------------------------------
	assign rx_bif.prescale = baud_ff[`SRX_BD_PRE_HI:`SRX_BD_PRE_LO];
	assign rx_bif.rate = baud_ff[`SRX_BD_RX_HI:`SRX_BD_RX_LO];
	assign rx_bif.fine = rxfine_ff;
	assign tx_bif.prescale = baud_ff[`SRX_BD_PRE_HI:`SRX_BD_PRE_LO];
	assign tx_bif.rate = baud_ff[`SRX_BD_TX_HI:`SRX_BD_TX_LO];
	assign tx_bif.fine = txfine_ff;

	srx_baud u_rx_baud (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.bif(rx_bif.gen)
	);

	srx_baud u_tx_baud (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.bif(tx_bif.gen)
	);

	assign tx_tick_o = tx_bif.tick;
	assign tk = rx_bif.tick;
	assign re = ctrl2_ff[`SRX_C2_RXEN];
	assign word9 = ctrl1_ff[`SRX_C1_WORD9];
	assign wake = ctrl1_ff[`SRX_C1_WAKE];
	assign bits_len = word9 ? `SRX_BITS9 : `SRX_BITS8;
	assign idle_len = word9 ? `SRX_IDLE9 : `SRX_IDLE8;

	// ------------------------------------------------------------
	// Line synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
		end
		else
		begin
			rx_meta_ff <= rdi_i;
			rx_sync_ff <= rx_meta_ff;
		end
	end

	// ------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------
	assign bit_end = tk && (samp_cnt_ff == `SRX_CNT_LAST);
	assign word_done = bit_end && (state_ff == ST_STOP);
	assign msb = shift_ff[8];

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i || !re)
		begin
			state_ff <= ST_IDLE;
			samp_cnt_ff <= 4'h0;
			bit_cnt_ff <= 4'h0;
		end
		else if (tk)
		begin
			samp_cnt_ff <= samp_cnt_ff + 4'h1;
			case (state_ff)
				ST_IDLE:
				begin
					samp_cnt_ff <= 4'h1;
					if (!rx_sync_ff && hist_ff[0])
					begin
						state_ff <= ST_START;
					end
				end
				ST_START:
				begin
					if (bit_end)
					begin
						state_ff <= maj3(trio_ff) ? ST_IDLE : ST_DATA;
						bit_cnt_ff <= 4'h0;
					end
				end
				ST_DATA:
				begin
					if (bit_end)
					begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == bits_len - 4'h1)
						begin
							state_ff <= ST_STOP;
						end
					end
				end
				default:
				begin
					if (bit_end)
					begin
						state_ff <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Sample history, noise tracking and data shifting
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			hist_ff <= 3'h7;
			trio_ff <= 3'h0;
			early_ff <= 1'b0;
			edge_ok_ff <= 1'b0;
			frame_noise_ff <= 1'b0;
			shift_ff <= 9'h000;
		end
		else if (tk)
		begin
			hist_ff <= {hist_ff[1:0], rx_sync_ff};
			if (state_ff == ST_IDLE)
			begin
				edge_ok_ff <= (hist_ff == 3'h7);
				early_ff <= 1'b0;
				frame_noise_ff <= 1'b0;
			end
			else
			begin
				if (samp_cnt_ff == `SRX_CNT_S3 || samp_cnt_ff == `SRX_CNT_S5
					|| samp_cnt_ff == `SRX_CNT_S7)
				begin
					early_ff <= early_ff | rx_sync_ff;
				end
				if (samp_cnt_ff >= `SRX_CNT_S8 && samp_cnt_ff <= `SRX_CNT_S10)
				begin
					trio_ff <= {trio_ff[1:0], rx_sync_ff};
				end
				if (samp_cnt_ff == `SRX_CNT_LAST)
				begin
					if (state_ff == ST_START)
					begin
						frame_noise_ff <= !edge_ok_ff || early_ff || (trio_ff != 3'h0);
					end
					else
					begin
						frame_noise_ff <= frame_noise_ff | differ3(trio_ff);
					end
					if (state_ff == ST_DATA)
					begin
						shift_ff <= {maj3(trio_ff), shift_ff[8:1]};
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Idle frame detection
	// ------------------------------------------------------------
	assign idle_evt = tk && re && (state_ff == ST_IDLE) && rx_sync_ff && idle_armed_ff
		&& (idle_cnt_ff == idle_len);

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			idle_cnt_ff <= 8'h00;
			idle_armed_ff <= 1'b0;
		end
		else
		begin
			if (word_done)
			begin
				idle_armed_ff <= 1'b1;
			end
			else if (idle_evt)
			begin
				idle_armed_ff <= 1'b0;
			end
			if (state_ff != ST_IDLE || (tk && !rx_sync_ff))
			begin
				idle_cnt_ff <= 8'h00;
			end
			else if (tk && idle_cnt_ff != idle_len)
			begin
				idle_cnt_ff <= idle_cnt_ff + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive flags
	// ------------------------------------------------------------
	assign wake_addr = word_done && mute_ff && wake && msb;
	assign accept = word_done && (!mute_ff || wake_addr);
	assign load = accept && !rxfull_ff;
	assign ovr_evt = accept && rxfull_ff;
	assign clr = rd_i && (addr_i == `SRX_OFS_DATA) && arm_ff;
	assign noise_now = frame_noise_ff || pend_noise_ff || differ3(trio_ff);

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			arm_ff <= 1'b0;
		end
		else if (rd_i && addr_i == `SRX_OFS_STATUS)
		begin
			arm_ff <= 1'b1;
		end
		else if (rd_i && addr_i == `SRX_OFS_DATA)
		begin
			arm_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			rxfull_ff <= 1'b0;
			ovr_ff <= 1'b0;
			noise_ff <= 1'b0;
			frame_ff <= 1'b0;
			idle_ff <= 1'b0;
		end
		else
		begin
			rxfull_ff <= accept || (rxfull_ff && !clr);
			ovr_ff <= ovr_evt || (ovr_ff && !clr);
			noise_ff <= (load && noise_now) || (noise_ff && !clr);
			frame_ff <= (load && !maj3(trio_ff)) || (frame_ff && !clr);
			idle_ff <= (idle_evt && !mute_ff) || (idle_ff && !clr);
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			pend_noise_ff <= 1'b0;
		end
		else if (bit_end && state_ff == ST_START && maj3(trio_ff))
		begin
			pend_noise_ff <= 1'b1;
		end
		else if (load)
		begin
			pend_noise_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			hold_ff <= `SRX_RST_REG;
		end
		else if (load)
		begin
			hold_ff <= word9 ? shift_ff[7:0] : shift_ff[8:1];
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			ctrl1_ff <= `SRX_RST_REG;
			ctrl2_ff <= `SRX_RST_REG;
			baud_ff <= `SRX_RST_REG;
			rxfine_ff <= `SRX_RST_REG;
			txfine_ff <= `SRX_RST_REG;
		end
		else
		begin
			if (wr_i && addr_i == `SRX_OFS_CTRL1)
			begin
				ctrl1_ff[6:0] <= wdata_i[6:0];
			end
			if (load && word9)
			begin
				ctrl1_ff[`SRX_C1_NINTH] <= msb;
			end
			if (wr_i && addr_i == `SRX_OFS_CTRL2)
			begin
				ctrl2_ff <= wdata_i;
			end
			if (wr_i && addr_i == `SRX_OFS_BAUD)
			begin
				baud_ff <= wdata_i;
			end
			if (wr_i && addr_i == `SRX_OFS_RXFINE)
			begin
				rxfine_ff <= wdata_i;
			end
			if (wr_i && addr_i == `SRX_OFS_TXFINE)
			begin
				txfine_ff <= wdata_i;
			end
		end
	end

	// Mute bit: software sets, wake events clear, a write wins
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			mute_ff <= 1'b0;
		end
		else if (wr_i && addr_i == `SRX_OFS_CTRL2)
		begin
			mute_ff <= wdata_i[`SRX_C2_MUTE];
		end
		else if (wake_addr || (idle_evt && mute_ff && !wake))
		begin
			mute_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupt and read path
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= !cpu_mask_i && !mute_ff &&
				((ctrl2_ff[`SRX_C2_RXIE] && (rxfull_ff || ovr_ff)) ||
				(ctrl2_ff[`SRX_C2_IDLEIE] && idle_ff));
		end
	end

	always_comb
	begin
		status = 8'h00;
		status[`SRX_ST_RXFULL] = rxfull_ff;
		status[`SRX_ST_IDLE] = idle_ff;
		status[`SRX_ST_OVR] = ovr_ff;
		status[`SRX_ST_NOISE] = noise_ff;
		status[`SRX_ST_FRAME] = frame_ff;
		data_val = {ctrl2_ff[7:2], mute_ff, ctrl2_ff[0]};
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i || !rd_i)
		begin
			rdata_ff <= 8'h00;
		end
		else
		begin
			case (addr_i)
				`SRX_OFS_STATUS: rdata_ff <= status;
				`SRX_OFS_DATA: rdata_ff <= hold_ff;
				`SRX_OFS_CTRL1: rdata_ff <= ctrl1_ff;
				`SRX_OFS_CTRL2: rdata_ff <= data_val;
				`SRX_OFS_BAUD: rdata_ff <= baud_ff;
				`SRX_OFS_RXFINE: rdata_ff <= rxfine_ff;
				`SRX_OFS_TXFINE: rdata_ff <= txfine_ff;
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	assign rdata_o = rdata_ff;
	assign irq_o = irq_ff;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	enable_idle_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		!re |=> state_ff == ST_IDLE)
		else $error("receiver active while disabled");
	word_load_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		load |=> rxfull_ff && hold_ff == (word9 ? $past(shift_ff[7:0]) : $past(shift_ff[8:1])))
		else $error("word not loaded into holding buffer");
	clear_order_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(rxfull_ff && !arm_ff && !accept) |=> rxfull_ff)
		else $error("full flag cleared without status access first");
	overrun_keep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		ovr_evt |=> ovr_ff && $stable(hold_ff))
		else $error("overrun did not keep buffer or set flag");
	irq_request_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(rxfull_ff && ctrl2_ff[`SRX_C2_RXIE] && !cpu_mask_i && !mute_ff) |=> irq_o)
		else $error("missing receive interrupt");
	mute_quiet_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(mute_ff && !wake_addr) |=> !$rose(rxfull_ff) && !$rose(idle_ff) && !$rose(frame_ff))
		else $error("flag raised while muted");
	idle_wake_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(idle_evt && mute_ff && !wake && !wr_i) |=> !mute_ff && !$rose(idle_ff))
		else $error("idle wake misbehaved");
	false_start_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(re && bit_end && state_ff == ST_START && maj3(trio_ff)) |=>
		state_ff == ST_IDLE && pend_noise_ff && !$rose(rxfull_ff))
		else $error("false start not discarded");
	noise_with_full_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$rose(noise_ff) |-> $rose(rxfull_ff))
		else $error("noise flag rose alone");
endmodule

// ==== testbench/srx_line_model.sv ====
module srx_line_model (
	// Clock
	input wire logic clk_i,
	// Serial line toward the receiver
	output logic line_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle line rests high
	initial line_o = 1'b1;

	// ------------------------------------------------------------
	// Frame and glitch drivers
	// ------------------------------------------------------------
	// Start, n data bits lsb first, stop level stp; g flips one cycle of bit 0
	task automatic send(input logic [8:0] d, input int n, input int per, input logic stp,
		input int g);
		logic v;
		for (int b = 0; b < n + 2; b++)
		begin
			for (int c = 0; c < per; c++)
			begin
				if (b == 0)
					v = 1'b0;
				else if (b > n)
					v = stp;
				else
					v = d[b - 1] ^ (b == 1 && c == g);
				@(posedge clk_i);
				line_o <= v;
			end
		end
		// Break frame needs a mark before the next start
		if (!stp)
		begin
			@(posedge clk_i);
			line_o <= 1'b1;
		end
	endtask

	// Short low pulse that looks like a start edge
	task automatic pulse(input int n);
		@(posedge clk_i);
		line_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		line_o <= 1'b1;
	endtask
endmodule

// ==== testbench/test_async_serial_receiver_baud_wakeup.sv ====
`include "srx_map.svh"

module test_async_serial_receiver_baud_wakeup;
	timeunit 1ns;
	timeprecision 1ns;
	import srx_pkg::*;

	logic ref_clk_i;
	logic nrst_i;
	srx_addr_type addr_i;
	srx_byte_type wdata_i;
	logic wr_i;
	logic rd_i;
	srx_byte_type rdata_o;
	logic rdi_i;
	logic cpu_mask_i;
	logic irq_o;
	logic tx_tick_o;
	int n_fail = 0;
	int comparisons = 0;

	typedef struct {logic [7:0] d; logic m; logic [7:0] c2; logic q;} srx_row_type;
	srx_row_type rows [4] = '{'{8'ha5, 1'b0, 8'h24, 1'b1}, '{8'h00, 1'b1, 8'h24, 1'b0},
		'{8'hff, 1'b0, 8'h04, 1'b0}, '{8'h3c, 1'b0, 8'h24, 1'b1}};
	logic [7:0] bsel [5] = '{8'hc0, 8'h42, 8'h80, 8'h00, 8'h01};
	logic [7:0] bfin [5] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h02};
	int bper [5] = '{208, 192, 64, 48, 64};

	srx_top dut_u (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.rdi_i(rdi_i),
		.cpu_mask_i(cpu_mask_i),
		.irq_o(irq_o),
		.tx_tick_o(tx_tick_o)
	);

	srx_line_model line_u (
		.clk_i(ref_clk_i),
		.line_o(rdi_i)
	);

	always #50 ref_clk_i = ~ref_clk_i;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input srx_addr_type a, input srx_byte_type d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		// Idle edge so the next strobe is not set in this step
		@(posedge ref_clk_i);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input srx_addr_type a, input srx_byte_type exp);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("rdata", rdata_o, exp);
		@(posedge ref_clk_i);
	endtask

	// Status, data, then status again after the clear sequence
	task automatic get(input srx_byte_type st, input srx_byte_type d);
		rd(`SRX_OFS_STATUS, st);
		rd(`SRX_OFS_DATA, d);
		rd(`SRX_OFS_STATUS, 8'h00);
	endtask

	task automatic ckirq(input logic e);
		@(negedge ref_clk_i);
		chk("irq", {7'h00, irq_o}, {7'h00, e});
		@(posedge ref_clk_i);
	endtask

	task automatic rx(input logic [8:0] d, input int n = 8, input int per = 16,
		input logic stp = 1'b1, input int g = -1);
		line_u.send(d, n, per, stp, g);
		cyc(per / 2 + 4);
	endtask

	task automatic ticks(input srx_byte_type exp);
		int n;
		n = 0;
		cyc(8);
		repeat (60)
		begin
			@(negedge ref_clk_i);
			n += (tx_tick_o === 1'b1) ? 1 : 0;
		end
		chk("tx_tick", n[7:0], exp);
		@(posedge ref_clk_i);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		ref_clk_i = 1'b0;
		nrst_i = 1'b0;
		addr_i = '0;
		wdata_i = '0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		cpu_mask_i = 1'b0;
		cyc(20);
		nrst_i <= 1'b1;
		cyc(1);
		foreach (rows[i])
		begin
			wr(`SRX_OFS_CTRL2, rows[i].c2);
			cpu_mask_i <= rows[i].m;
			rx({1'b0, rows[i].d});
			ckirq(rows[i].q);
			get(8'h20, rows[i].d);
		end
		$display("test plain frames done");
		wr(`SRX_OFS_CTRL2, 8'h14);
		cyc(170);
		ckirq(1'b1);
		get(8'h10, 8'h3c);
		$display("test idle frame done");
		wr(`SRX_OFS_CTRL2, 8'h24);
		line_u.send(9'h011, 8, 16, 1'b1, -1);
		rx(9'h022);
		get(8'h28, 8'h11);
		rx(9'h000, 8, 16, 1'b0);
		get(8'h22, 8'h00);
		rx(9'h000, 8, 16, 1'b1, 8);
		get(8'h24, 8'h00);
		line_u.pulse(4);
		cyc(40);
		rd(`SRX_OFS_STATUS, 8'h00);
		rx(9'h05a);
		get(8'h24, 8'h5a);
		$display("test errors done");
		wr(`SRX_OFS_CTRL1, 8'h10);
		rx(9'h1a5, 9);
		rd(`SRX_OFS_CTRL1, 8'h90);
		get(8'h20, 8'ha5);
		$display("test nine bits done");
		wr(`SRX_OFS_CTRL1, 8'h00);
		wr(`SRX_OFS_CTRL2, 8'h36);
		rx(9'h077);
		ckirq(1'b0);
		rd(`SRX_OFS_STATUS, 8'h00);
		cyc(200);
		rd(`SRX_OFS_CTRL2, 8'h34);
		rd(`SRX_OFS_STATUS, 8'h00);
		wr(`SRX_OFS_CTRL1, 8'h08);
		// Mute set in the last control write before the wake
		wr(`SRX_OFS_CTRL2, 8'h26);
		rx(9'h012);
		ckirq(1'b0);
		rd(`SRX_OFS_STATUS, 8'h00);
		rx(9'h093);
		ckirq(1'b1);
		rd(`SRX_OFS_CTRL2, 8'h24);
		get(8'h20, 8'h93);
		$display("test mute done");
		foreach (bsel[i])
		begin
			// Rates change only with the receiver off
			wr(`SRX_OFS_CTRL2, 8'h00);
			wr(`SRX_OFS_BAUD, bsel[i]);
			wr(`SRX_OFS_RXFINE, bfin[i]);
			wr(`SRX_OFS_CTRL2, 8'h04);
			cyc(4 * bper[i]);
			rx(9'h0c6, 8, bper[i]);
			get(8'h20, 8'hc6);
		end
		wr(`SRX_OFS_CTRL2, 8'h00);
		wr(`SRX_OFS_BAUD, 8'h08);
		ticks(8'h1e);
		wr(`SRX_OFS_TXFINE, 8'h03);
		ticks(8'h0a);
		$display("test baud done");
		nrst_i <= 1'b0;
		cyc(2);
		nrst_i <= 1'b1;
		cyc(1);
		wr(3'h7, 8'hff);
		for (int a = 0; a < 8; a++)
			rd(a[2:0], 8'h00);
		rx(9'h05a);
		rd(`SRX_OFS_STATUS, 8'h00);
		wr(`SRX_OFS_CTRL2, 8'h04);
		cyc(4);
		rx(9'h05a);
		get(8'h20, 8'h5a);
		$display("test reset done");
		print_verdict();
	end

	initial
	begin
		cyc(40000);
		n_fail++;
		print_verdict();
	end
endmodule
